// ==== rtl/air_pkg.sv ====
// air_pkg: shared constants for the converter register bank
// assumes: one clock domain, device end and host end joined by air_if
package air_pkg;
	// ============================================================
	// register addresses and layouts
	localparam logic [7:0] ADDR_IFMODE = 8'h02;
	localparam logic [7:0] ADDR_CHECK  = 8'h03;
	localparam logic [7:0] ADDR_RESULT = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_USER0  = 8'h10;
	localparam int         NUM_USER    = 4;
	localparam int         BIT_SHORT_WORD = 0;
	localparam int         BIT_CHECK   = 5;
	localparam int         BIT_APPEND  = 6;
	localparam int         CRC_LO      = 2;
	localparam logic [7:0] IFMODE_MASK = 8'h6D;
	localparam logic [7:0] IFMODE_RST  = 8'h00;
	localparam logic [23:0] CHECK_RST  = 24'h000000;
	localparam logic [23:0] RESULT_RST = 24'h000000;
	localparam int         STAT_RDYB   = 7;
	localparam int         STAT_REGERR = 6;
	// ============================================================
	// transfer check modes
	localparam logic [1:0] XFER_NONE = 2'h0;
	localparam logic [1:0] XFER_XOR  = 2'h1;
	localparam logic [1:0] XFER_CRC  = 2'h2;
	// ============================================================
	// host-side control registers (word index)
	localparam logic [3:0] H_CMD    = 4'h0;
	localparam logic [3:0] H_RDATA  = 4'h1;
	localparam logic [3:0] H_STAT   = 4'h2;
	localparam logic [3:0] H_IRQST  = 4'h3;
	localparam logic [3:0] H_IRQCLR = 4'h4;
	localparam logic [3:0] H_IRQEN  = 4'h5;
	localparam logic [3:0] H_RSTAT  = 4'h6;
	localparam int         NUM_IRQ  = 3;
	localparam int         IRQ_DONE = 0;
	localparam int         IRQ_RDY  = 1;
	localparam int         IRQ_ERR  = 2;
endpackage

// ==== rtl/air_if.sv ====
// air_if: register access link between host end and device end
// assumes: both ends clocked by the same clock
`timescale 1ns/1ps
interface air_if;
	logic        req;
	logic        wr;
	logic [7:0]  addr;
	logic [23:0] wdata;
	logic [7:0]  wcheck;
	logic        ack;
	logic [31:0] rdata;
	logic [7:0]  rcheck;
	logic        rlong;
	logic        rdy_b;
	logic [1:0]  xfer_mode;
	modport device (input req, wr, addr, wdata, wcheck, output ack, rdata, rcheck, rlong, rdy_b, xfer_mode);
	modport host   (output req, wr, addr, wdata, wcheck, input ack, rdata, rcheck, rlong, rdy_b, xfer_mode);
endinterface

// ==== rtl/air_check.sv ====
// air_check: transfer check byte generator (xor or crc-8)
// assumes: purely combinational, used by both ends
`timescale 1ns/1ps
module air_check (
	// selection
	input  wire logic [1:0]  mode_i,
	// data under check
	input  wire logic [39:0] data_i,
	output logic      [7:0]  check_o
);
	import air_pkg::*;
	logic [7:0] crc;
	logic [7:0] x;
	always_comb begin
		crc = 8'h00;
		x = 8'h00;
		for (int i = 39; i >= 0; i--) begin
			crc = (crc[7] ^ data_i[i]) ? ((crc << 1) ^ 8'h07) : (crc << 1);
		end
		for (int b = 0; b < 5; b++) begin
			x = x ^ data_i[b*8 +: 8];
		end
		check_o = (mode_i == XFER_XOR) ? x : crc;
	end
endmodule

// ==== rtl/air_device.sv ====
// air_device: converter interface-mode, checksum and result registers
// assumes: host follows the link handshake; results arrive as one-cycle strobes
// assumes: RESULT_I is two's complement; one clock for converter and link
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module air_device #(
	parameter int RES_W = 24
) (
	// clock and reset
	input  wire logic             CLOCK_I,
	input  wire logic             RST_B_I,
	// link
	air_if.device                 link,
	// converter side
	input  wire logic             RESULT_VALID_I,
	input  wire logic [RES_W-1:0] RESULT_I,
	input  wire logic             POLARITY_SELECT_I,
	input  wire logic [3:0]       CHANNEL_I,
	// status out
	output logic                  RDY_B_O,
	output logic                  CHECK_ERROR_O
);
	import air_pkg::*;
	// ============================================================
	// state
	typedef struct packed {
		logic [7:0]              ifmode;
		logic [NUM_USER-1:0][23:0] user;
		logic [23:0]             ref_sum;
		logic                    reg_error;
		logic [23:0]             result;
		logic                    result_short;
		logic [3:0]              channel;
		logic                    rdy_b;
		logic                    reading;
		logic                    ack;
		logic [31:0]             rdata;
		logic                    rlong;
		logic [7:0]              rcheck;
	} air_dev_t;
	air_dev_t s_r, s_nxt;
	logic [23:0] sum;
	logic [7:0]  status;
	logic [31:0] rd_word;
	logic [7:0]  wchk;
	logic [7:0]  rchk;
	logic        wr_ok;
	logic [23:0] conv;
	logic        take;
	logic        res_read;
	logic        load_ok;
	logic        check_on;
	logic        sum_bad;
	logic [1:0]  xfer_sel;
	logic [NUM_USER-1:0] user_hit;
	// ============================================================
	// checksum and check bytes
	always_comb begin
		sum = 24'h000000;
		for (int i = 0; i < NUM_USER; i++) begin
			sum = sum ^ s_r.user[i];
		end
	end
	air_check u_wchk (
		.mode_i  (XFER_CRC),
		.data_i  ({link.wr, 7'h00, link.addr, link.wdata}),
		.check_o (wchk)
	);
	air_check u_rchk (
		.mode_i  (xfer_sel),
		.data_i  ({link.addr, rd_word}),
		.check_o (rchk)
	);
	assign status = {s_r.rdy_b, s_r.reg_error, 2'h0, s_r.channel};
	// write rejected on a bad check byte when a transfer check mode is selected
	assign wr_ok = (xfer_sel == XFER_NONE) || (link.wcheck == wchk);
	// polarity: offset binary by default, straight binary when unipolar
	assign conv = POLARITY_SELECT_I ? 24'(RESULT_I) : (24'(RESULT_I) ^ 24'h800000);
	// ============================================================
	// request decode
	assign take = link.req && !s_r.ack;
	assign check_on = s_r.ifmode[BIT_CHECK];
	assign xfer_sel = s_r.ifmode[CRC_LO +: 2];
	// result read blocks loads from the take edge; ack cycle is covered by reading
	assign res_read = link.req && !link.wr && link.addr == ADDR_RESULT;
	// limitation: a result arriving inside that window is dropped, not queued
	assign load_ok = RESULT_VALID_I && !res_read && !s_r.reading;
	// compared one cycle behind the write, so a watched write flags a cycle late
	assign sum_bad = check_on && sum != s_r.ref_sum;
	for (genvar g = 0; g < NUM_USER; g++) begin : g_user
		assign user_hit[g] = link.addr == ADDR_USER0 + 8'(g);
	end
	// ============================================================
	// read mux
	always_comb begin
		rd_word = 32'h00000000;
		unique case (link.addr)
			ADDR_IFMODE: rd_word = {24'h000000, s_r.ifmode & IFMODE_MASK};
			ADDR_CHECK:  rd_word = {8'h00, check_on ? sum : CHECK_RST};
			ADDR_STATUS: rd_word = {24'h000000, status};
			ADDR_RESULT: begin
				if (s_r.result_short) begin
					rd_word = {16'h0000, s_r.result[23:8]};
				end else begin
					rd_word = {8'h00, s_r.result};
				end
				if (s_r.ifmode[BIT_APPEND]) begin
					rd_word = {rd_word[23:0], status};
				end
			end
			// unmapped addresses read as zero
			default: begin
				for (int i = 0; i < NUM_USER; i++) begin
					if (user_hit[i]) begin
						rd_word = {8'h00, s_r.user[i]};
					end
				end
			end
		endcase
	end
	// ============================================================
	// next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = 1'b0;
		s_nxt.reading = 1'b0;
		if (take) begin
			s_nxt.ack = 1'b1;
			if (link.wr) begin
				if (wr_ok) begin
					if (link.addr == ADDR_IFMODE) begin
						s_nxt.ifmode = link.wdata[7:0] & IFMODE_MASK;
						if (!link.wdata[BIT_CHECK]) begin
							s_nxt.reg_error = 1'b0;
						end else if (!s_r.ifmode[BIT_CHECK]) begin
							s_nxt.ref_sum = sum;
						end
					end
					for (int i = 0; i < NUM_USER; i++) begin
						if (user_hit[i]) begin
							s_nxt.user[i] = link.wdata;
						end
					end
				end
			end else begin
				// data and check byte frozen at the take edge, held until the next read
				s_nxt.rdata = rd_word;
				s_nxt.rcheck = rchk;
				s_nxt.rlong = (link.addr == ADDR_RESULT) && s_r.ifmode[BIT_APPEND];
				if (link.addr == ADDR_RESULT) begin
					s_nxt.rdy_b = 1'b1;
					s_nxt.reading = 1'b1;
				end
			end
		end
		// new result blocked while a result read is under way
		if (load_ok) begin
			s_nxt.result = conv;
			s_nxt.result_short = s_r.ifmode[BIT_SHORT_WORD];
			s_nxt.channel = CHANNEL_I;
			s_nxt.rdy_b = 1'b0;
		end
		// set and clear cannot meet: clearing needs the enable bit dropping
		if (sum_bad && s_nxt.ifmode[BIT_CHECK]) begin
			s_nxt.reg_error = 1'b1;
		end
	end
	// ============================================================
	// registers
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			s_r <= '0;
			// ready idles high: nothing unread after reset
			s_r.rdy_b <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end
	// ============================================================
	// outputs
	assign link.ack = s_r.ack;
	assign link.rdata = s_r.rdata;
	assign link.rcheck = s_r.rcheck;
	assign link.rlong = s_r.rlong;
	assign link.rdy_b = s_r.rdy_b;
	assign link.xfer_mode = xfer_sel;
	assign RDY_B_O = s_r.rdy_b;
	assign CHECK_ERROR_O = s_r.reg_error;
endmodule

// ==== rtl/air_host.sv ====
// air_host: host end; software orders transfers through a small register port
// assumes: device end answers each request with a one-cycle ack
`timescale 1ns/1ps
module air_host (
	// clock and reset
	input  wire logic        CLOCK_I,
	input  wire logic        RST_B_I,
	// link
	air_if.host              link,
	// software port
	input  wire logic [3:0]  ADDR_I,
	input  wire logic [31:0] WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output logic      [31:0] RDATA_O,
	output logic             IRQ_O
);
	import air_pkg::*;
	// ============================================================
	// state
	typedef struct packed {
		logic              busy;
		logic              req;
		logic              wr;
		logic [7:0]        addr;
		logic [23:0]       wdata;
		logic [31:0]       rdata;
		logic              check_bad;
		logic              rdy_b_d;
		logic [NUM_IRQ-1:0] irq_st;
		logic [NUM_IRQ-1:0] irq_en;
		logic [31:0]       sw_rdata;
	} air_host_t;
	air_host_t s_r, s_nxt;
	logic [7:0] wchk;
	logic [7:0] rchk;
	logic [NUM_IRQ-1:0] ev;
	air_check u_wchk (
		.mode_i  (XFER_CRC),
		.data_i  ({1'b1, 7'h00, s_r.addr, s_r.wdata}),
		.check_o (wchk)
	);
	air_check u_rchk (
		.mode_i  (link.xfer_mode),
		.data_i  ({s_r.addr, link.rdata}),
		.check_o (rchk)
	);
	// ============================================================
	// next state
	always_comb begin
		s_nxt = s_r;
		ev = '0;
		s_nxt.rdy_b_d = link.rdy_b;
		if (s_r.req && link.ack) begin
			s_nxt.req = 1'b0;
			s_nxt.busy = 1'b0;
			ev[IRQ_DONE] = 1'b1;
			if (!s_r.wr) begin
				s_nxt.rdata = link.rdata;
				// extra check byte expected when a transfer check mode is selected
				s_nxt.check_bad = (link.xfer_mode != XFER_NONE) && (link.rcheck != rchk);
				ev[IRQ_ERR] = (link.xfer_mode != XFER_NONE) && (link.rcheck != rchk);
			end
		end
		ev[IRQ_RDY] = s_r.rdy_b_d && !link.rdy_b;
		s_nxt.sw_rdata = 32'h00000000;
		if (RD_I) begin
			unique case (ADDR_I)
				H_RDATA: s_nxt.sw_rdata = s_r.rdata;
				H_STAT:  s_nxt.sw_rdata = {29'h0, s_r.check_bad, link.rdy_b, s_r.busy};
				H_IRQST: s_nxt.sw_rdata = 32'(s_r.irq_st);
				H_IRQEN: s_nxt.sw_rdata = 32'(s_r.irq_en);
				H_CMD:   s_nxt.sw_rdata = {s_r.wr, 15'h0, s_r.addr, 8'h00};
				default: s_nxt.sw_rdata = 32'h00000000;
			endcase
		end
		if (WR_I) begin
			unique case (ADDR_I)
				H_CMD: begin
					// ignored while busy; software polls busy first
					if (!s_r.busy) begin
						s_nxt.busy = 1'b1;
						s_nxt.req = 1'b1;
						s_nxt.wr = WDATA_I[31];
						s_nxt.addr = WDATA_I[31:24] & 8'h7F;
						s_nxt.wdata = WDATA_I[23:0];
					end
				end
				H_IRQCLR: s_nxt.irq_st = s_r.irq_st & ~WDATA_I[NUM_IRQ-1:0];
				H_IRQEN:  s_nxt.irq_en = WDATA_I[NUM_IRQ-1:0];
				default: ;
			endcase
		end
		s_nxt.irq_st = s_nxt.irq_st | ev;
	end
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			s_r <= '0;
			s_r.rdy_b_d <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign link.req = s_r.req;
	assign link.wr = s_r.wr;
	assign link.addr = s_r.addr;
	assign link.wdata = s_r.wdata;
	assign link.wcheck = wchk;
	assign RDATA_O = s_r.sw_rdata;
	assign IRQ_O = |(s_r.irq_st & s_r.irq_en);
endmodule

// ==== test/air_chk.sv ====
// air_chk: link-level checks between host end and device end
// assumes: instantiated beside air_if, one clock, async low reset
`timescale 1ns/1ps
module air_chk (
	// clock and reset
	input wire logic        CLOCK_I,
	input wire logic        RST_B_I,
	// link
	input wire logic        req,
	input wire logic        wr,
	input wire logic [7:0]  addr,
	input wire logic [23:0] wdata,
	input wire logic [7:0]  wcheck,
	input wire logic        ack,
	input wire logic [31:0] rdata,
	input wire logic [7:0]  rcheck,
	input wire logic        rlong,
	input wire logic        rdy_b,
	input wire logic [1:0]  xfer_mode
);
	import air_pkg::*;
	// ============================================================
	// shadow of the mode bits, taken from acknowledged writes
	logic       on_r;
	logic       app_r;
	logic [1:0] md_r;
	logic       mw;
	logic       rr;
	assign mw = ack && wr && addr == ADDR_IFMODE;
	assign rr = ack && !wr && addr == ADDR_RESULT;
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			on_r <= 1'b0;
			app_r <= 1'b0;
			md_r <= XFER_NONE;
		end else if (mw) begin
			on_r <= wdata[BIT_CHECK];
			app_r <= wdata[BIT_APPEND];
			md_r <= wdata[3:2];
		end
	end
	// ============================================================
	// properties
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RST_B_I);
	ack_pulse_a: assert property (ack |=> !ack) else $error("ack longer than one cycle");
	ack_answer_a: assert property (req && !ack |=> ack) else $error("request not answered");
	ack_cause_a: assert property ($rose(ack) |-> $past(req)) else $error("ack without request");
	rdy_read_a: assert property (rr |-> ##[0:1] rdy_b) else $error("ready low after read");
	sum_zero_a: assert property (ack && !wr && addr == ADDR_CHECK && !on_r |-> rdata[23:0] == 24'h000000)
		else $error("checksum nonzero while off");
	resv_zero_a: assert property (ack && !wr && addr == ADDR_IFMODE |-> !rdata[4] && !rdata[1])
		else $error("reserved mode bits set");
	mode_track_a: assert property (!ack && !$past(ack) |-> xfer_mode == md_r)
		else $error("transfer mode differs");
	append_long_a: assert property (rr |-> rlong == app_r) else $error("long read mismatch");
	cover property (rr && app_r);
	cover property (mw && wdata[BIT_CHECK]);
	cover property (ack && xfer_mode == XFER_CRC);
endmodule

// ==== test/tb_top.sv ====
// tb_top: host end and device end face to face, driven from the software port
// assumes: air_pkg, air_if, air_check, air_device, air_host compiled first
`timescale 1ns/1ps
module tb_top;
	import air_pkg::*;
	logic        clk;
	logic        rst_b;
	logic        wr;
	logic        rd;
	logic        rv;
	logic        pol;
	logic        rdy_b;
	logic        cerr;
	logic        irq;
	logic [3:0]  ad;
	logic [3:0]  ch;
	logic [31:0] wd;
	logic [31:0] rdat;
	logic [31:0] v;
	logic [23:0] res;
	int          n_errors;
	int          tests_run;
	int          i;
	air_if lk ();
	air_device i_air_device (.CLOCK_I(clk), .RST_B_I(rst_b), .link(lk), .RESULT_VALID_I(rv), .RESULT_I(res),
		.POLARITY_SELECT_I(pol), .CHANNEL_I(ch), .RDY_B_O(rdy_b), .CHECK_ERROR_O(cerr));
	air_host i_air_host (.CLOCK_I(clk), .RST_B_I(rst_b), .link(lk), .ADDR_I(ad), .WDATA_I(wd), .WR_I(wr),
		.RD_I(rd), .RDATA_O(rdat), .IRQ_O(irq));
	air_chk i_air_chk (.CLOCK_I(clk), .RST_B_I(rst_b), .req(lk.req), .wr(lk.wr), .addr(lk.addr),
		.wdata(lk.wdata), .wcheck(lk.wcheck), .ack(lk.ack), .rdata(lk.rdata), .rcheck(lk.rcheck),
		.rlong(lk.rlong), .rdy_b(lk.rdy_b), .xfer_mode(lk.xfer_mode));
	// ============================================================
	// tasks
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic sw(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		ad <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic sr(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		ad <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdat;
	endtask
	// one link transfer; answer left in v
	task automatic lx(input logic w, input logic [7:0] a, input logic [23:0] d);
		int k;
		sw(H_CMD, {w, a[6:0], d});
		v = 32'h00000001;
		for (k = 0; k < 20 && v[0] !== 1'b0; k++) sr(H_STAT, v);
		sr(H_RDATA, v);
	endtask
	task automatic pr(input logic [23:0] r, input logic [3:0] c);
		@(posedge clk);
		res <= r;
		ch <= c;
		rv <= 1'b1;
		@(posedge clk);
		rv <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk(rdy_b, 32'h0);
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ============================================================
	// clock, watchdog, tests
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#40000;
		n_errors++;
		close_out();
	end
	initial begin
		rst_b = 1'b0;
		{wr, rd, rv, pol, ad, ch, wd, res} = '0;
		n_errors = 0;
		tests_run = 0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		lx(1'b0, ADDR_RESULT, 24'h0);
		chk(v, 32'h0);
		lx(1'b0, ADDR_CHECK, 24'h0);
		chk(v, 32'h0);
		chk(rdy_b, 32'h1);
		sr(4'hF, v);
		chk(v, 32'h0);
		$display("test reset done");
		pr(24'h123456, 4'h5);
		for (i = 0; i < 2; i++) begin
			lx(1'b0, ADDR_RESULT, 24'h0);
			chk(v, 32'h00923456);
			chk(rdy_b, 32'h1);
		end
		@(posedge clk);
		pol <= 1'b1;
		pr(24'h8000FF, 4'h1);
		lx(1'b0, ADDR_RESULT, 24'h0);
		chk(v, 32'h008000FF);
		// result arriving at the take edge of a result read is refused
		sw(H_CMD, {1'b0, ADDR_RESULT[6:0], 24'h000000});
		res <= 24'h777777;
		rv <= 1'b1;
		@(posedge clk);
		rv <= 1'b0;
		v = 32'h00000001;
		for (i = 0; i < 20 && v[0] !== 1'b0; i++) sr(H_STAT, v);
		sr(H_RDATA, v);
		chk(v, 32'h008000FF);
		chk(rdy_b, 32'h1);
		$display("test result done");
		lx(1'b1, ADDR_IFMODE, 24'h000001);
		lx(1'b0, ADDR_RESULT, 24'h0);
		chk(v, 32'h008000FF);
		pr(24'hABCD12, 4'h2);
		lx(1'b0, ADDR_RESULT, 24'h0);
		chk(v, 32'h0000ABCD);
		lx(1'b1, ADDR_IFMODE, 24'h000040);
		pr(24'h123456, 4'h3);
		lx(1'b0, ADDR_RESULT, 24'h0);
		chk(32'({v[31:8], v[5:0]}), 32'({24'h123456, 6'h03}));
		lx(1'b0, ADDR_IFMODE, 24'h0);
		chk(v, 32'h00000040);
		$display("test width done");
		for (i = 0; i < NUM_USER; i++) lx(1'b1, 8'(ADDR_USER0 + i), 24'h111111 << i);
		lx(1'b1, ADDR_IFMODE, 24'h000020);
		lx(1'b0, ADDR_CHECK, 24'h0);
		chk(v, 32'h00FFFFFF);
		chk(cerr, 32'h0);
		lx(1'b1, ADDR_IFMODE, 24'h000021);
		chk(cerr, 32'h0);
		lx(1'b1, ADDR_USER0, 24'h0);
		chk(cerr, 32'h1);
		lx(1'b0, ADDR_STATUS, 24'h0);
		chk(v[STAT_REGERR], 32'h1);
		lx(1'b1, ADDR_IFMODE, 24'h0);
		chk(cerr, 32'h0);
		lx(1'b0, ADDR_CHECK, 24'h0);
		chk(v, 32'h0);
		$display("test integrity done");
		for (i = 1; i < 3; i++) begin
			lx(1'b1, ADDR_IFMODE, 24'(i << CRC_LO));
			lx(1'b0, 8'(ADDR_USER0 + 1), 24'h0);
			chk(v, 32'h00222222);
			if (i == 1) chk(lk.rcheck, 32'h00000033);
			sr(H_STAT, v);
			chk(v[2], 32'h0);
			lx(1'b1, ADDR_IFMODE, 24'h0);
		end
		$display("test transfer check done");
		sw(H_IRQCLR, 32'h7);
		sw(H_IRQEN, 32'h1);
		lx(1'b0, ADDR_STATUS, 24'h0);
		chk(irq, 32'h1);
		sw(H_IRQCLR, 32'h7);
		sw(H_IRQEN, 32'h0);
		lx(1'b0, ADDR_STATUS, 24'h0);
		chk(irq, 32'h0);
		sr(H_IRQST, v);
		chk(v, 32'h00000001);
		sw(H_IRQEN, 32'h2);
		pr(24'h000000, 4'h0);
		chk(irq, 32'h1);
		$display("test interrupt done");
		close_out();
	end
endmodule
